// ---- core/fwp_pkg.sv ----
// Constants and types shared by the flash write-protection logic.
package fwp_pkg;

  // Command opcodes seen on the serial link.
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_FOUR_LINE_PROGRAM = 8'h32;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
  localparam logic [7:0] CMD_SMALL_PARAM_ERASE = 8'h20;
  localparam logic [7:0] CMD_LARGE_PARAM_ERASE = 8'h40;
  localparam logic [7:0] CMD_FULL_ERASE = 8'hc7;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'h42;

  // Status register bit positions.
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 6;
  localparam int ST_LOCK = 7;

  // Configuration register bit positions.
  localparam int CF_FREEZE = 0;
  localparam int CF_QUAD = 1;
  localparam int CF_PARAM_LOC = 2;
  localparam int CF_VOLATILE = 3;
  localparam int CF_ORIGIN = 5;

  // Block-protect value loaded at power-on when the bits are volatile.
  localparam logic [2:0] BP_VOLATILE_RESET = 3'h7;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [6:0] SECTOR_COUNT = 7'h40;
  localparam int SECTOR_LSB = 16;
  // Parameter region: 32 sectors of 4 KB, one 128 KB span.
  localparam int PARAM_LSB = 17;
  localparam logic [4:0] PARAM_TOP = 5'h1f;

  // Frame length in bytes needed by the address and data command families.
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_DATA = 3'h5;

  // Register write busy time.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REG_WRITE_NS = 5000;
  localparam int REG_WRITE_CYCLES =
    (REG_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    FWP_IDLE = 2'b00,
    FWP_REG_WRITE = 2'b01,
    FWP_ARRAY_OP = 2'b10
  } fwp_state_t;

  typedef enum logic [2:0] {
    FWP_OP_PROGRAM = 3'h0,
    FWP_OP_SECTOR_ERASE = 3'h1,
    FWP_OP_SMALL_ERASE = 3'h2,
    FWP_OP_LARGE_ERASE = 3'h3,
    FWP_OP_FULL_ERASE = 3'h4,
    FWP_OP_OTP_PROGRAM = 3'h5
  } fwp_op_t;

endpackage

// ---- core/fwp_flash_protect.sv ----
// Status, configuration and write protection of a serial NOR flash.
`timescale 1ns/1ps

module fwp_flash_protect
  import fwp_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int REG_WRITE_LEN = REG_WRITE_CYCLES
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  input wire logic write_protect_pin,
  // Non-volatile image, loaded after reset and stored after each accepted register write
  input wire logic nv_lock_in,
  input wire logic [2:0] nv_bp_in,
  input wire logic [7:0] nv_config_in,
  output logic nv_store,
  output logic [7:0] nv_status_out,
  output logic [7:0] nv_config_out,
  // Array operation request and completion
  output logic op_start,
  output fwp_pkg::fwp_op_t op_kind,
  output logic [ADDR_W-1:0] op_addr,
  input wire logic op_done,
  input wire logic op_fail,
  // Mode indications
  output logic quad_mode,
  output logic hard_protect_state,
  output logic busy_flag
);

  initial begin
    if (ADDR_W != 22) begin
      $error("fwp_flash_protect: ADDR_W must be 22");
    end
    if (REG_WRITE_LEN < 1 || REG_WRITE_LEN > 65535) begin
      $error("fwp_flash_protect: REG_WRITE_LEN out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: sck. Frame data is held after the frame so that the clk
  // domain can read it once chip select is seen high; sck must stay idle
  // while chip select is high.

  logic in_frame;
  logic frame_tog;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] op_sh;
  logic [23:0] arg_sh;
  logic [7:0] snap_status;
  logic [7:0] snap_config;

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      frame_tog <= 1'b0;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      op_sh <= 8'h00;
      arg_sh <= 24'h000000;
    end else if (!in_frame) begin
      frame_tog <= ~frame_tog;
      bit_cnt <= 3'h1;
      byte_cnt <= 3'h0;
      op_sh <= {7'h00, si};
      arg_sh <= 24'h000000;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_cnt == 3'h0) begin
        op_sh <= {op_sh[6:0], si};
      end else if (byte_cnt < LEN_ADDR) begin
        arg_sh <= {arg_sh[22:0], si};
      end
      if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // Register reads shift out on the falling edge, most significant first.
  // The quad bit does not touch this path, so plain reads keep working.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_oe <= 1'b0;
      so_out <= 1'b0;
    end else if (in_frame && byte_cnt != 3'h0 &&
                 op_sh == CMD_READ_STATUS) begin
      so_oe <= 1'b1;
      so_out <= snap_status[3'h7 - bit_cnt];
    end else if (in_frame && byte_cnt != 3'h0 &&
                 op_sh == CMD_READ_CONFIG) begin
      so_oe <= 1'b1;
      so_out <= snap_config[3'h7 - bit_cnt];
    end else begin
      so_oe <= 1'b0;
      so_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the clk domain.

  logic cs_meta;
  logic cs_sync;
  logic cs_dly;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic wp_meta;
  logic wp_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_dly <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else if (ce) begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_dly <= cs_sync;
      tog_meta <= frame_tog;
      tog_sync <= tog_meta;
      wp_meta <= write_protect_pin;
      wp_sync <= wp_meta;
    end
  end

  logic frame_end;
  assign frame_end = ce && cs_sync && !cs_dly && (tog_sync != tog_seen);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_seen <= 1'b0;
    end else if (ce && cs_sync && !cs_dly) begin
      tog_seen <= tog_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state and protection decode.

  fwp_state_t state;
  logic loaded;
  logic write_enable_latch;
  logic [2:0] bp;
  logic lock;
  logic erase_err;
  logic prog_err;
  logic freeze;
  logic quad;
  logic param_top;
  logic volatile_bp;
  logic origin_bottom;
  logic [15:0] reg_timer;
  logic [7:0] status_word;
  logic [7:0] config_word;
  logic hw_protect;

  always_comb begin
    status_word = 8'h00;
    status_word[ST_BUSY] = state != FWP_IDLE;
    status_word[ST_WEL] = write_enable_latch;
    status_word[ST_BP_LO +: 3] = bp;
    status_word[ST_ERASE_ERR] = erase_err;
    status_word[ST_PROG_ERR] = prog_err;
    status_word[ST_LOCK] = lock;
    config_word = 8'h00;
    config_word[CF_FREEZE] = freeze;
    config_word[CF_QUAD] = quad;
    config_word[CF_PARAM_LOC] = param_top;
    config_word[CF_VOLATILE] = volatile_bp;
    config_word[CF_ORIGIN] = origin_bottom;
  end

  // In quad mode the protect pin is a data line and cannot protect.
  assign hw_protect = lock && !wp_sync && !quad;

  // Snapshots change only between frames, so the link reads stable words.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_status <= 8'h00;
      snap_config <= 8'h00;
    end else if (ce && cs_sync) begin
      snap_status <= status_word;
      snap_config <= config_word;
    end
  end

  function automatic logic addr_protected(input logic [21:0] addr,
                                          input logic [2:0] code,
                                          input logic from_bottom);
    logic [6:0] span;
    logic [6:0] sect;
    span = 7'h01 << (code - 3'h1);
    sect = {1'b0, addr[21:SECTOR_LSB]};
    if (code == 3'h0) begin
      addr_protected = 1'b0;
    end else if (code == BP_ALL) begin
      addr_protected = 1'b1;
    end else if (from_bottom) begin
      addr_protected = sect < span;
    end else begin
      addr_protected = sect >= SECTOR_COUNT - span;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at frame end.

  logic [21:0] cmd_addr;
  logic aligned;
  logic is_array;
  logic [2:0] need_len;
  fwp_op_t cmd_kind;
  logic in_param;
  logic refuse;

  assign cmd_addr = arg_sh[21:0];
  assign aligned = bit_cnt == 3'h0;
  assign in_param = param_top ? (cmd_addr[21:PARAM_LSB] == PARAM_TOP)
                              : (cmd_addr[21:PARAM_LSB] == 5'h00);

  always_comb begin
    is_array = 1'b1;
    need_len = LEN_ADDR;
    cmd_kind = FWP_OP_PROGRAM;
    case (op_sh)
      CMD_PAGE_PROGRAM, CMD_FOUR_LINE_PROGRAM: begin
        need_len = LEN_DATA;
      end
      CMD_OTP_PROGRAM: begin
        need_len = LEN_DATA;
        cmd_kind = FWP_OP_OTP_PROGRAM;
      end
      CMD_SECTOR_ERASE: begin
        cmd_kind = FWP_OP_SECTOR_ERASE;
      end
      CMD_SMALL_PARAM_ERASE: begin
        cmd_kind = FWP_OP_SMALL_ERASE;
      end
      CMD_LARGE_PARAM_ERASE: begin
        cmd_kind = FWP_OP_LARGE_ERASE;
      end
      CMD_FULL_ERASE: begin
        need_len = 3'h1;
        cmd_kind = FWP_OP_FULL_ERASE;
      end
      default: begin
        is_array = 1'b0;
      end
    endcase
  end

  // Protected targets are refused; the array is never asked to change.
  always_comb begin
    case (cmd_kind)
      FWP_OP_FULL_ERASE: refuse = bp != 3'h0;
      FWP_OP_OTP_PROGRAM: refuse = 1'b0;
      FWP_OP_SMALL_ERASE, FWP_OP_LARGE_ERASE:
        refuse = !in_param || addr_protected(cmd_addr, bp, origin_bottom);
      default: refuse = addr_protected(cmd_addr, bp, origin_bottom);
    endcase
  end

  logic take_wrr;
  logic take_array;
  logic array_go;
  logic idle_cmd;

  assign idle_cmd = frame_end && loaded && state == FWP_IDLE;
  assign take_wrr = idle_cmd && op_sh == CMD_REGISTER_WRITE && write_enable_latch &&
                    aligned && byte_cnt >= 3'h2;
  assign take_array = idle_cmd && is_array && write_enable_latch && aligned &&
                      byte_cnt >= need_len;
  assign array_go = take_array && !refuse;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and busy flag.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FWP_IDLE;
      reg_timer <= 16'h0000;
    end else if (ce) begin
      case (state)
        FWP_IDLE: begin
          if (take_wrr) begin
            state <= FWP_REG_WRITE;
            reg_timer <= 16'(REG_WRITE_LEN - 1);
          end else if (array_go) begin
            state <= FWP_ARRAY_OP;
          end
        end
        FWP_REG_WRITE: begin
          if (reg_timer == 16'h0000) begin
            state <= FWP_IDLE;
          end else begin
            reg_timer <= reg_timer - 16'h0001;
          end
        end
        FWP_ARRAY_OP: begin
          if (op_done) begin
            state <= FWP_IDLE;
          end
        end
        default: begin
          state <= FWP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_start <= 1'b0;
      op_kind <= FWP_OP_PROGRAM;
      op_addr <= '0;
    end else if (ce) begin
      op_start <= array_go;
      if (array_go) begin
        op_kind <= cmd_kind;
        op_addr <= cmd_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write enable latch.

  logic wel_clear;
  assign wel_clear = (state == FWP_REG_WRITE && reg_timer == 16'h0000) ||
                     (state == FWP_ARRAY_OP && op_done) ||
                     (take_array && refuse) ||
                     (idle_cmd && op_sh == CMD_WRITE_DISABLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (ce) begin
      if (idle_cmd && op_sh == CMD_WRITE_ENABLE) begin
        write_enable_latch <= 1'b1;
      end else if (wel_clear) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags: set by a failed completion, cleared when the next
  // operation of the same family starts.

  logic erase_kind;
  logic prog_kind;
  assign erase_kind = op_kind != FWP_OP_PROGRAM &&
                      op_kind != FWP_OP_OTP_PROGRAM;
  assign prog_kind = !erase_kind;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_err <= 1'b0;
      prog_err <= 1'b0;
    end else if (ce) begin
      if (state == FWP_ARRAY_OP && op_done) begin
        erase_err <= erase_kind ? op_fail : erase_err;
        prog_err <= prog_kind ? op_fail : prog_err;
      end else if (op_start) begin
        erase_err <= erase_kind ? 1'b0 : erase_err;
        prog_err <= prog_kind ? 1'b0 : prog_err;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and configuration bits. The non-volatile image is loaded on the
  // first enabled cycle after reset; freeze is volatile and starts clear.

  logic [7:0] wr_status;
  logic [7:0] wr_config;
  logic wr_has_config;
  assign wr_has_config = byte_cnt >= 3'h3;

  // The argument register fills from the low end, so where the status and
  // configuration bytes sit depends on how many bytes the frame carried.
  always_comb begin
    wr_status = arg_sh[7:0];
    wr_config = 8'h00;
    if (byte_cnt == 3'h3) begin
      wr_status = arg_sh[15:8];
      wr_config = arg_sh[7:0];
    end else if (byte_cnt > 3'h3) begin
      wr_status = arg_sh[23:16];
      wr_config = arg_sh[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
      lock <= 1'b0;
      bp <= 3'h0;
      freeze <= 1'b0;
      quad <= 1'b0;
      param_top <= 1'b0;
      volatile_bp <= 1'b0;
      origin_bottom <= 1'b0;
    end else if (ce) begin
      if (!loaded) begin
        loaded <= 1'b1;
        lock <= nv_lock_in;
        bp <= nv_config_in[CF_VOLATILE] ? BP_VOLATILE_RESET
                                        : nv_bp_in;
        quad <= nv_config_in[CF_QUAD];
        param_top <= nv_config_in[CF_PARAM_LOC];
        volatile_bp <= nv_config_in[CF_VOLATILE];
        origin_bottom <= nv_config_in[CF_ORIGIN];
      end else if (take_wrr) begin
        if (!hw_protect) begin
          lock <= wr_status[ST_LOCK];
        end
        if (!hw_protect && !freeze) begin
          bp <= wr_status[ST_BP_LO +: 3];
        end
        if (wr_has_config) begin
          freeze <= freeze | wr_config[CF_FREEZE];
          quad <= wr_config[CF_QUAD];
          volatile_bp <= volatile_bp | wr_config[CF_VOLATILE];
          if (!freeze) begin
            param_top <= param_top | wr_config[CF_PARAM_LOC];
            origin_bottom <=
              origin_bottom | wr_config[CF_ORIGIN];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic store_pend;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_pend <= 1'b0;
      nv_store <= 1'b0;
      nv_status_out <= 8'h00;
      nv_config_out <= 8'h00;
      quad_mode <= 1'b0;
      hard_protect_state <= 1'b0;
      busy_flag <= 1'b0;
    end else if (ce) begin
      // The image registers show the new bits two cycles after take_wrr is
      // taken, so the store strobe waits for them.
      store_pend <= take_wrr;
      nv_store <= store_pend;
      nv_status_out <= status_word;
      // The freeze bit is volatile and never enters the stored image.
      nv_config_out <= config_word & ~(8'h01 << CF_FREEZE);
      quad_mode <= quad;
      hard_protect_state <= hw_protect;
      busy_flag <= status_word[ST_BUSY];
    end
  end

endmodule

// ---- tb/fwp_props.sv ----
// Concurrent checks on the ports of the flash protection block.
`timescale 1ns/1ps
module fwp_props
  import fwp_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int REG_WRITE_LEN = REG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Array operation handshake
  input wire logic op_start,
  input wire fwp_pkg::fwp_op_t op_kind,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic op_done,
  input wire logic op_fail,
  // Register images and modes
  input wire logic nv_store,
  input wire logic [7:0] nv_status_out,
  input wire logic [7:0] nv_config_out,
  input wire logic quad_mode,
  input wire logic hard_protect_state,
  input wire logic busy_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  start_busy_a: assert property (op_start |-> ##[0:2] busy_flag)
    else $error("busy flag missing after array start");
  done_idle_a: assert property (op_done && busy_flag
    |-> ##[1:3] !busy_flag)
    else $error("busy flag stuck after completion");
  latch_clear_a: assert property (op_done && busy_flag
    |-> ##[1:4] !nv_status_out[ST_WEL])
    else $error("enable latch kept after completion");
  prog_err_a: assert property (op_done && busy_flag && op_fail
    && op_kind == FWP_OP_PROGRAM |-> ##[1:4] nv_status_out[ST_PROG_ERR])
    else $error("program error flag not set");
  unused_bits_a: assert property (nv_config_out[7:6] == 2'h0
    && !nv_config_out[4] && !nv_config_out[CF_FREEZE])
    else $error("unused configuration bits not zero");
  onetime_bits_a: assert property ((nv_config_out & 8'h2c) != 8'h00
    |=> ($past(nv_config_out) & ~nv_config_out & 8'h2c) == 8'h00)
    else $error("one-time configuration bit cleared");
  quad_pin_a: assert property (quad_mode [*3] |-> !hard_protect_state)
    else $error("pin protection active in quad mode");
  hard_hold_a: assert property (hard_protect_state [*3]
    |-> $stable({nv_status_out[ST_LOCK], nv_status_out[4:2]}))
    else $error("protected status bits changed");
  target_hold_a: assert property (!op_start
    |-> $stable(op_kind) && $stable(op_addr))
    else $error("operation target changed without a start");
  store_busy_a: assert property (nv_store
    |-> busy_flag ##1 !nv_store)
    else $error("image store outside a register write");

  cover property (op_start && op_kind == FWP_OP_SECTOR_ERASE);
  cover property (hard_protect_state);
  cover property (nv_store && quad_mode);
endmodule

// ---- tb/fwp_spi_host.sv ----
// Serial host model that frames commands towards the flash block.
`timescale 1ns/1ps
module fwp_spi_host (
  // Serial link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Mode 0, MSB first; the clock stands still outside frames and the data
  // line is inverted on release so a stale level is never mistaken.
  task automatic frame(input logic [39:0] d, input int n,
                       output logic [7:0] rd);
    rd = 8'h00;
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = d[39-i];
      #24 sck = 1'b1;
      if (i >= 8 && i < 16) begin
        rd[15-i] = so_out & so_oe;
      end
      #24 sck = 1'b0;
    end
    #10 cs_n = 1'b1;
    si = ~si;
    // Long gap keeps cs high well past the frame processing delay.
    #100;
  endtask
endmodule

// ---- tb/fwp_flash_protect_tb.sv ----
// Self-checking bench for the flash write-protection block.
`timescale 1ns/1ps
module fwp_flash_protect_tb;
  import fwp_pkg::*;
  logic clk, rst_n, sck, cs_n, si, so_out, so_oe, wp_pin, nv_lock_in;
  logic op_done, op_fail, quad_mode, hard_protect_state, busy_flag;
  logic op_start, nv_store;
  logic [2:0] nv_bp_in;
  logic [7:0] nv_config_in, nv_status_out, nv_config_out, rd;
  fwp_op_t op_kind;
  logic [21:0] op_addr;
  int failures, compares, starts;

  fwp_flash_protect #(.ADDR_W(22), .REG_WRITE_LEN(4)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .sck(sck), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe), .write_protect_pin(wp_pin),
    .nv_lock_in(nv_lock_in), .nv_bp_in(nv_bp_in),
    .nv_config_in(nv_config_in), .nv_store(nv_store),
    .nv_status_out(nv_status_out), .nv_config_out(nv_config_out),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .op_done(op_done), .op_fail(op_fail), .quad_mode(quad_mode),
    .hard_protect_state(hard_protect_state), .busy_flag(busy_flag));

  fwp_spi_host i_host (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [39:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic idle();
    int i;
    for (i = 0; i < 400 && busy_flag !== 1'b0; i++) @(posedge clk);
    if (i == 400) begin
      failures++;
      $display("unexpected busy: expected 0 seen 1");
      close_out();
    end
  endtask

  task automatic do_reset(input logic [7:0] cfg);
    #1 rst_n = 1'b0;
    nv_config_in = cfg;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic cmd(input logic [39:0] d, input int n);
    i_host.frame(d, n, rd);
    idle();
  endtask

  task automatic rchk(input logic [7:0] c, m, e);
    i_host.frame({c, 32'h0}, 16, rd);
    check("register", rd & m, e);
  endtask

  task automatic write_enable_cmd();
    cmd({CMD_WRITE_ENABLE, 32'h0}, 8);
  endtask

  task automatic register_write_cmd(input logic [7:0] st, cf);
    write_enable_cmd();
    cmd({CMD_REGISTER_WRITE, st, cf, 16'h0}, 24);
  endtask

  // Array request; the bench plays the array and ends it with op_done.
  task automatic op(input logic [7:0] c, input logic [23:0] a,
                    input logic go, f, input logic [2:0] k);
    int s0;
    s0 = starts;
    write_enable_cmd();
    i_host.frame({c, a, 8'h00}, 40, rd);
    check("start count", starts - s0, go);
    if (go) begin
      check("kind", op_kind, k);
      check("addr", op_addr, a[21:0]);
      check("busy", busy_flag, 1'b1);
      @(posedge clk);
      #1 op_done = 1'b1;
      op_fail = f;
      @(posedge clk);
      #1 op_done = 1'b0;
    end
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    rchk(CMD_READ_STATUS, 8'hff, 8'h1c);
    rchk(CMD_READ_CONFIG, 8'hff, 8'h08);
    do_reset(8'h00);
    rchk(CMD_READ_STATUS, 8'hff, 8'h00);
    $display("power test done");
  endtask

  task automatic t_wel();
    write_enable_cmd();
    rchk(CMD_READ_STATUS, 8'hff, 8'h02);
    cmd({CMD_WRITE_DISABLE, 32'h0}, 8);
    rchk(CMD_READ_STATUS, 8'hff, 8'h00);
    $display("latch test done");
  endtask

  task automatic t_top();
    logic [7:0] c[6] = '{8'h02, 8'h32, 8'hd8, 8'h20, 8'h40, 8'h42};
    logic [23:0] a[6] = '{24'h3e0000, 24'h3e0100, 24'h010000, 24'h001000,
                          24'h002000, 24'h000100};
    logic [2:0] k[6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    register_write_cmd(8'h04, 8'h00);
    rchk(CMD_READ_STATUS, 8'hff, 8'h04);
    for (int i = 0; i < 6; i++) begin
      op(c[i], a[i], 1'b1, i[0], k[i]);
      rchk(CMD_READ_STATUS, (k[i] == 3'h1 || k[i] == 3'h2 || k[i] == 3'h3)
           ? 8'h23 : 8'h43, i[0] ? ((k[i] == 3'h0 || k[i] == 3'h5)
           ? 8'h40 : 8'h20) : 8'h00);
    end
    op(CMD_PAGE_PROGRAM, 24'h3f0000, 1'b0, 1'b0, 3'h0);
    op(CMD_FULL_ERASE, 24'h000000, 1'b0, 1'b0, 3'h4);
    rchk(CMD_READ_STATUS, 8'hff, 8'h44);
    write_enable_cmd();
    i_host.frame({CMD_PAGE_PROGRAM, 24'h3e0000, 8'h0}, 41, rd);
    rchk(CMD_READ_STATUS, 8'hff, 8'h46);
    $display("top origin test done");
  endtask

  task automatic t_bottom();
    register_write_cmd(8'h18, 8'h24);
    rchk(CMD_READ_CONFIG, 8'hff, 8'h24);
    op(CMD_SECTOR_ERASE, 24'h1f0000, 1'b0, 1'b0, 3'h1);
    op(CMD_SECTOR_ERASE, 24'h200000, 1'b1, 1'b0, 3'h1);
    op(CMD_SMALL_PARAM_ERASE, 24'h3e1000, 1'b1, 1'b0, 3'h2);
    op(CMD_SMALL_PARAM_ERASE, 24'h201000, 1'b0, 1'b0, 3'h2);
    register_write_cmd(8'h18, 8'h00);
    rchk(CMD_READ_CONFIG, 8'hff, 8'h24);
    $display("bottom origin test done");
  endtask

  task automatic t_hard();
    register_write_cmd(8'h98, 8'h24);
    #1 wp_pin = 1'b0;
    repeat (8) @(posedge clk);
    #1 check("hard", hard_protect_state, 1'b1);
    register_write_cmd(8'h00, 8'h24);
    rchk(CMD_READ_STATUS, 8'h9c, 8'h98);
    register_write_cmd(8'h98, 8'h26);
    check("quad", quad_mode, 1'b1);
    check("hard", hard_protect_state, 1'b0);
    register_write_cmd(8'h00, 8'h26);
    rchk(CMD_READ_STATUS, 8'h9c, 8'h00);
    #1 wp_pin = 1'b1;
    $display("hardware protect test done");
  endtask

  task automatic t_freeze();
    register_write_cmd(8'h04, 8'h27);
    register_write_cmd(8'h10, 8'h02);
    rchk(CMD_READ_STATUS, 8'h1c, 8'h04);
    rchk(CMD_READ_CONFIG, 8'hff, 8'h27);
    do_reset(8'h00);
    rchk(CMD_READ_CONFIG, 8'h01, 8'h00);
    $display("freeze test done");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wp_pin = 1'b1;
    nv_lock_in = 1'b0;
    nv_bp_in = 3'h0;
    op_done = 1'b0;
    op_fail = 1'b0;
    failures = 0;
    compares = 0;
    starts = 0;
    do_reset(8'h08);
    t_power();
    t_wel();
    t_top();
    t_bottom();
    t_hard();
    t_freeze();
    close_out();
  end
endmodule

bind fwp_flash_protect fwp_props #(.ADDR_W(ADDR_W),
  .REG_WRITE_LEN(REG_WRITE_LEN)) i_props (.clk(clk), .rst_n(rst_n),
  .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
  .op_done(op_done), .op_fail(op_fail), .nv_store(nv_store),
  .nv_status_out(nv_status_out), .nv_config_out(nv_config_out),
  .quad_mode(quad_mode), .hard_protect_state(hard_protect_state),
  .busy_flag(busy_flag));
